// *** verilog/hw_cfg_params.svh ***
`ifndef HW_CFG_PARAMS_SVH
`define HW_CFG_PARAMS_SVH

// Contract
// - Pattern select picks channel transmit source
// - Global attenuator select; 00 disables it
// - 01: receive path, broad, 64-bit FIFO
// - 10: receive path, narrow, 128-bit FIFO
// - 11: transmit path, narrow, 128-bit FIFO
// - Ternary hardware mode: gain 0 or 26 dB
// - Loopback select: none, analog, digital, remote
// - No in-band loopback in hardware mode
// - Driver high-impedance control acts on both drivers
// - Edge select: low rising, high falling
// - Ternary hardware mode: short or long haul

// ==========================================================
// Register map (byte addresses)
`define HWCFG_CTRL_OFS 12'h000
`define HWCFG_SWCFG_OFS 12'h004
`define HWCFG_CHSTAT_OFS 12'h008
`define HWCFG_GLBSTAT_OFS 12'h00C
`define HWCFG_PINS_OFS 12'h010

// ==========================================================
// Field positions and widths
`define HWCFG_CTRL_HWMODE_BIT 0
`define HWCFG_CTRL_TERNARY_BIT 1
`define HWCFG_CTRL_W 2
`define HWCFG_SWCFG_INBAND_BIT 16
`define HWCFG_SWCFG_W 17
`define HWCFG_PINS_W 16
`define HWCFG_PINS_EDGE_BIT 15
`define HWCFG_PINS_HIZ_BIT 14
`define HWCFG_PINS_JA_LSB 12
`define HWCFG_PINS_CH1_LSB 6
`define HWCFG_PINS_CH0_LSB 0
`define HWCFG_CHSTAT_CH0_LSB 0
`define HWCFG_CHSTAT_CH1_LSB 16
`define HWCFG_GLBSTAT_JA_LSB 0
`define HWCFG_GLBSTAT_EDGE_BIT 16
`define HWCFG_GLBSTAT_INBAND_BIT 17

// ==========================================================
// Reset values
`define HWCFG_CTRL_RST 2'h3
`define HWCFG_SWCFG_RST 17'h04000

// ==========================================================
// Attenuator FIFO depths in bits
`define HWCFG_JA_FIFO_NONE 8'h00
`define HWCFG_JA_FIFO_BROAD 8'h40
`define HWCFG_JA_FIFO_NARROW 8'h80

`endif

// *** verilog/hw_cfg_pkg.sv ***
package hw_cfg_pkg;

  // ==========================================================
  // Encodings of the selector pins
  typedef enum logic [1:0] {
    TX_NORMAL = 2'h0,
    TX_ALL_ONES = 2'h1,
    TX_PRBS = 2'h2,
    TX_POWER_DOWN = 2'h3
  } txPattern_t;

  typedef enum logic [1:0] {
    LOOP_NONE = 2'h0,
    LOOP_ANALOG = 2'h1,
    LOOP_DIGITAL = 2'h2,
    LOOP_REMOTE = 2'h3
  } loopback_t;

  typedef enum logic [1:0] {
    JA_OFF = 2'h0,
    JA_RX_BROAD = 2'h1,
    JA_RX_NARROW = 2'h2,
    JA_TX_NARROW = 2'h3
  } jaSel_t;

  // ==========================================================
  // Pin bundles
  typedef struct packed {
    txPattern_t txPatternSel;
    loopback_t loopbackSel;
    logic rxMonitorGainSel;
    logic haulModeSel;
  } chanPins_t;

  typedef struct packed {
    logic rxClockEdgeSel;
    logic txDriverHiz;
    jaSel_t jitterAttenSel;
    chanPins_t [1:0] chan;
  } cfgPins_t;

  // ==========================================================
  // Decoded settings
  typedef struct packed {
    txPattern_t txSource;
    logic txPowerDown;
    logic txDriverEn;
    loopback_t loopMode;
    logic monitorGain26dB;
    logic longHaul;
  } chanCfg_t;

  typedef struct packed {
    logic enable;
    logic inTxPath;
    logic narrowBw;
    logic [7:0] fifoDepth;
  } jaCfg_t;

  // ==========================================================
  // Registers and module state
  typedef struct packed {
    logic ternaryIf;
    logic hwMode;
  } ctrl_t;

  typedef struct packed {
    logic inbandEn;
    cfgPins_t cfg;
  } swCfg_t;

  typedef struct packed {
    ctrl_t ctrl;
    swCfg_t sw;
    cfgPins_t pinsR;
    logic [31:0] rdata;
    logic ready;
    logic slvErr;
    logic rxClkFalling;
    logic inbandEn;
  } mainState_t;

endpackage : hw_cfg_pkg

// *** verilog/channel_cfg_decode.sv ***
`include "hw_cfg_params.svh"

module channel_cfg_decode (
  // Clock and reset
  input logic clk,
  input logic rstn,
  // Selected settings for this channel
  input hw_cfg_pkg::chanPins_t pins,
  input logic analogSelEn,
  input logic driverHiz,
  // Decoded settings
  output hw_cfg_pkg::chanCfg_t cfg
);

  localparam hw_cfg_pkg::chanCfg_t CFG_RST = '{
    txSource: hw_cfg_pkg::TX_POWER_DOWN,
    txPowerDown: 1'b1,
    txDriverEn: 1'b0,
    loopMode: hw_cfg_pkg::LOOP_NONE,
    monitorGain26dB: 1'b0,
    longHaul: 1'b0
  };

  hw_cfg_pkg::chanCfg_t cfg_r;
  hw_cfg_pkg::chanCfg_t cfg_nxt;

  function automatic logic isPowerDown(input hw_cfg_pkg::txPattern_t sel);
    return sel == hw_cfg_pkg::TX_POWER_DOWN;
  endfunction : isPowerDown

  // ==========================================================
  // Decode
  always_comb begin
    cfg_nxt.txSource = pins.txPatternSel;
    cfg_nxt.txPowerDown = isPowerDown(pins.txPatternSel);
    // A powered-down transmitter never drives, whatever the hi-z control says
    cfg_nxt.txDriverEn = !driverHiz && !isPowerDown(pins.txPatternSel);
    cfg_nxt.loopMode = pins.loopbackSel;
    cfg_nxt.monitorGain26dB = analogSelEn && pins.rxMonitorGainSel;
    cfg_nxt.longHaul = analogSelEn && pins.haulModeSel;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      cfg_r <= CFG_RST;
    end else begin
      cfg_r <= cfg_nxt;
    end
  end

  assign cfg = cfg_r;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  chk_tx_pattern_map: assert property (
    $past(rstn) |-> cfg.txSource == $past(pins.txPatternSel)
      && cfg.txPowerDown == ($past(pins.txPatternSel) == hw_cfg_pkg::TX_POWER_DOWN))
    else $error("transmit source does not follow pattern select");

  chk_driver_hiz: assert property (
    $past(rstn) && $past(driverHiz) |-> !cfg.txDriverEn)
    else $error("driver enabled while high impedance requested");

  chk_driver_enable: assert property (
    $past(rstn) && !$past(driverHiz) && $past(pins.txPatternSel) != hw_cfg_pkg::TX_POWER_DOWN
      |-> cfg.txDriverEn)
    else $error("driver not enabled while hi-z control low");

  chk_loopback_map: assert property (
    $past(rstn) |-> cfg.loopMode == $past(pins.loopbackSel))
    else $error("loopback mode does not follow select");

  chk_gain_gate: assert property (
    $past(rstn) |-> cfg.monitorGain26dB == ($past(analogSelEn) && $past(pins.rxMonitorGainSel)))
    else $error("monitor gain wrong");

  chk_haul_gate: assert property (
    $past(rstn) |-> cfg.longHaul == ($past(analogSelEn) && $past(pins.haulModeSel)))
    else $error("haul mode wrong");

endmodule : channel_cfg_decode

// *** verilog/jitter_atten_decode.sv ***
`include "hw_cfg_params.svh"

module jitter_atten_decode (
  // Clock and reset
  input logic clk,
  input logic rstn,
  // Global attenuator select
  input hw_cfg_pkg::jaSel_t sel,
  // Decoded attenuator settings
  output hw_cfg_pkg::jaCfg_t cfg
);

  localparam hw_cfg_pkg::jaCfg_t CFG_RST = '{
    enable: 1'b0,
    inTxPath: 1'b0,
    narrowBw: 1'b0,
    fifoDepth: `HWCFG_JA_FIFO_NONE
  };

  hw_cfg_pkg::jaCfg_t cfg_r;
  hw_cfg_pkg::jaCfg_t cfg_nxt;

  // ==========================================================
  // Decode
  always_comb begin
    cfg_nxt = CFG_RST;
    unique case (sel)
      hw_cfg_pkg::JA_OFF: begin
        cfg_nxt = CFG_RST;
      end
      hw_cfg_pkg::JA_RX_BROAD: begin
        cfg_nxt.enable = 1'b1;
        cfg_nxt.fifoDepth = `HWCFG_JA_FIFO_BROAD;
      end
      hw_cfg_pkg::JA_RX_NARROW: begin
        cfg_nxt.enable = 1'b1;
        cfg_nxt.narrowBw = 1'b1;
        cfg_nxt.fifoDepth = `HWCFG_JA_FIFO_NARROW;
      end
      hw_cfg_pkg::JA_TX_NARROW: begin
        cfg_nxt.enable = 1'b1;
        cfg_nxt.inTxPath = 1'b1;
        cfg_nxt.narrowBw = 1'b1;
        cfg_nxt.fifoDepth = `HWCFG_JA_FIFO_NARROW;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      cfg_r <= CFG_RST;
    end else begin
      cfg_r <= cfg_nxt;
    end
  end

  assign cfg = cfg_r;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  chk_ja_off: assert property (
    $past(rstn) && $past(sel) == hw_cfg_pkg::JA_OFF
      |-> !cfg.enable && cfg.fifoDepth == 8'h00)
    else $error("attenuator not disabled");

  chk_ja_rx_broad: assert property (
    $past(rstn) && $past(sel) == hw_cfg_pkg::JA_RX_BROAD
      |-> cfg.enable && !cfg.inTxPath && !cfg.narrowBw && cfg.fifoDepth == 8'h40)
    else $error("attenuator setting 01 wrong");

  chk_ja_rx_narrow: assert property (
    $past(rstn) && $past(sel) == hw_cfg_pkg::JA_RX_NARROW
      |-> cfg.enable && !cfg.inTxPath && cfg.narrowBw && cfg.fifoDepth == 8'h80)
    else $error("attenuator setting 10 wrong");

  chk_ja_tx_narrow: assert property (
    $past(rstn) && $past(sel) == hw_cfg_pkg::JA_TX_NARROW
      |-> cfg.enable && cfg.inTxPath && cfg.narrowBw && cfg.fifoDepth == 8'h80)
    else $error("attenuator setting 11 wrong");

endmodule : jitter_atten_decode

// *** verilog/hw_mode_config_pin_decoder.sv ***
// Our own choices: the placing of the registers and register access over APB.
`include "hw_cfg_params.svh"

module hw_mode_config_pin_decoder (
  // Clock and reset
  input logic clk,
  input logic rstn,
  // APB slave
  input logic [11:0] paddr,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Configuration pins
  input hw_cfg_pkg::cfgPins_t cfgPins,
  // Decoded per-channel settings
  output hw_cfg_pkg::chanCfg_t [1:0] chanCfg,
  // Decoded global settings
  output hw_cfg_pkg::jaCfg_t jaCfg,
  output logic rxClkFalling,
  output logic inbandLoopEn
);

  localparam hw_cfg_pkg::mainState_t MAIN_RST = '{
    ctrl: hw_cfg_pkg::ctrl_t'(`HWCFG_CTRL_RST),
    sw: hw_cfg_pkg::swCfg_t'(`HWCFG_SWCFG_RST),
    pinsR: '0,
    rdata: 32'h0000_0000,
    ready: 1'b0,
    slvErr: 1'b0,
    rxClkFalling: 1'b0,
    inbandEn: 1'b0
  };

  hw_cfg_pkg::mainState_t s_r;
  hw_cfg_pkg::mainState_t s_nxt;
  hw_cfg_pkg::cfgPins_t effCfg;
  logic analogSelEn;
  logic [31:0] rdWord;
  logic setupPhase;
  logic accessDone;

  function automatic logic addrMapped(input logic [11:0] addr);
    return addr == `HWCFG_CTRL_OFS || addr == `HWCFG_SWCFG_OFS
      || addr == `HWCFG_CHSTAT_OFS || addr == `HWCFG_GLBSTAT_OFS
      || addr == `HWCFG_PINS_OFS;
  endfunction : addrMapped

  // ==========================================================
  // Source selection
  // Pins rule in hardware mode; the software image stands in otherwise
  always_comb begin
    effCfg = s_r.ctrl.hwMode ? s_r.pinsR : s_r.sw.cfg;
    // Gain and haul pins only mean something with the ternary interface
    analogSelEn = !s_r.ctrl.hwMode || s_r.ctrl.ternaryIf;
  end

  // ==========================================================
  // Per-channel and attenuator decoders
  for (genvar ch = 0; ch < 2; ch++) begin : gChan
    channel_cfg_decode uChan (
      .clk(clk),
      .rstn(rstn),
      .pins(effCfg.chan[ch]),
      .analogSelEn(analogSelEn),
      .driverHiz(effCfg.txDriverHiz),
      .cfg(chanCfg[ch])
    );
  end

  jitter_atten_decode uJa (
    .clk(clk),
    .rstn(rstn),
    .sel(effCfg.jitterAttenSel),
    .cfg(jaCfg)
  );

  // ==========================================================
  // Read mux
  always_comb begin
    rdWord = 32'h0000_0000;
    unique case (paddr)
      `HWCFG_CTRL_OFS: begin
        rdWord[`HWCFG_CTRL_W-1:0] = s_r.ctrl;
      end
      `HWCFG_SWCFG_OFS: begin
        rdWord[`HWCFG_SWCFG_W-1:0] = s_r.sw;
      end
      `HWCFG_CHSTAT_OFS: begin
        rdWord[`HWCFG_CHSTAT_CH0_LSB +: $bits(hw_cfg_pkg::chanCfg_t)] = chanCfg[0];
        rdWord[`HWCFG_CHSTAT_CH1_LSB +: $bits(hw_cfg_pkg::chanCfg_t)] = chanCfg[1];
      end
      `HWCFG_GLBSTAT_OFS: begin
        rdWord[`HWCFG_GLBSTAT_JA_LSB +: $bits(hw_cfg_pkg::jaCfg_t)] = jaCfg;
        rdWord[`HWCFG_GLBSTAT_EDGE_BIT] = s_r.rxClkFalling;
        rdWord[`HWCFG_GLBSTAT_INBAND_BIT] = s_r.inbandEn;
      end
      `HWCFG_PINS_OFS: begin
        rdWord[`HWCFG_PINS_W-1:0] = s_r.pinsR;
      end
      default: begin
        rdWord = 32'h0000_0000;
      end
    endcase
  end

  // ==========================================================
  // Next state
  assign setupPhase = psel && !penable;
  assign accessDone = psel && penable && s_r.ready;

  always_comb begin
    s_nxt = s_r;
    // Pins are static straps; each field but the pattern select, which also gates txDriverEn, feeds only its own setting
    s_nxt.pinsR = cfgPins;
    // One wait-free access phase: answer is prepared during setup
    s_nxt.ready = setupPhase;
    s_nxt.slvErr = setupPhase && !addrMapped(paddr);
    if (setupPhase && !pwrite) begin
      s_nxt.rdata = rdWord;
    end
    if (accessDone && pwrite && addrMapped(paddr)) begin
      unique case (paddr)
        `HWCFG_CTRL_OFS: begin
          s_nxt.ctrl = hw_cfg_pkg::ctrl_t'(pwdata[`HWCFG_CTRL_W-1:0]);
        end
        `HWCFG_SWCFG_OFS: begin
          s_nxt.sw = hw_cfg_pkg::swCfg_t'(pwdata[`HWCFG_SWCFG_W-1:0]);
        end
        default: begin
          s_nxt.sw = s_r.sw;
        end
      endcase
    end
    s_nxt.rxClkFalling = effCfg.rxClockEdgeSel;
    // In-band loopback exists only under software control
    s_nxt.inbandEn = !s_r.ctrl.hwMode && s_r.sw.inbandEn;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      s_r <= MAIN_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================
  // Outputs
  assign prdata = s_r.rdata;
  assign pready = s_r.ready;
  assign pslverr = s_r.slvErr;
  assign rxClkFalling = s_r.rxClkFalling;
  assign inbandLoopEn = s_r.inbandEn;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  sequence edgeStrapHigh;
    s_r.ctrl.hwMode && cfgPins.rxClockEdgeSel ##1 s_r.ctrl.hwMode && s_r.pinsR.rxClockEdgeSel;
  endsequence

  sequence edgeStrapLow;
    s_r.ctrl.hwMode && !cfgPins.rxClockEdgeSel ##1 s_r.ctrl.hwMode && !s_r.pinsR.rxClockEdgeSel;
  endsequence

  sequence ctrlWrite;
    psel && !penable && pwrite && paddr == `HWCFG_CTRL_OFS ##1 psel && penable && pready;
  endsequence

  chk_edge_falling: assert property (
    edgeStrapHigh |=> rxClkFalling)
    else $error("falling edge not selected with strap high");

  chk_edge_rising: assert property (
    edgeStrapLow |=> !rxClkFalling)
    else $error("rising edge not selected with strap low");

  chk_no_inband: assert property (
    $past(rstn) && $past(s_r.ctrl.hwMode) |-> !inbandLoopEn)
    else $error("in-band loopback offered in hardware mode");

  chk_hw_pattern_path: assert property (
    s_r.ctrl.hwMode ##1 s_r.ctrl.hwMode && $stable(s_r.pinsR)
      |=> chanCfg[0].txSource == $past(s_r.pinsR.chan[0].txPatternSel))
    else $error("pattern pin not reaching channel decoder");

  chk_hw_ternary_gate: assert property (
    s_r.ctrl.hwMode && !s_r.ctrl.ternaryIf |=> !chanCfg[0].monitorGain26dB
      && !chanCfg[1].monitorGain26dB && !chanCfg[0].longHaul && !chanCfg[1].longHaul)
    else $error("gain or haul applied without ternary interface");

  chk_apb_answer: assert property (
    psel && !penable |=> pready ##1 !pready)
    else $error("access phase not exactly one cycle");

  chk_ctrl_write: assert property (
    ctrlWrite |=> s_r.ctrl == $past(pwdata[1:0]))
    else $error("control register write lost");

  chk_unmapped_err: assert property (
    psel && !penable && !addrMapped(paddr) |=> pready && pslverr)
    else $error("unmapped address not flagged");

endmodule : hw_mode_config_pin_decoder

// *** tb/cfg_strap_model.sv ***
module cfg_strap_model (
  // Clock
  input logic clk,
  // Level requested by the bench
  input hw_cfg_pkg::cfgPins_t req,
  // Strap levels seen by the device
  output hw_cfg_pkg::cfgPins_t pins
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // Straps
  // Straps only move right after an edge, then hold still
  initial pins = '0;
  always @(posedge clk) begin
    pins <= req;
  end
endmodule : cfg_strap_model

// *** tb/tb_hw_mode_config_pin_decoder.sv ***
module tb_hw_mode_config_pin_decoder;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // Signals
  logic clk;
  logic rstn;
  logic [11:0] paddr;
  logic psel;
  logic penable;
  logic pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  hw_cfg_pkg::cfgPins_t strapReq;
  hw_cfg_pkg::cfgPins_t cfgPins;
  hw_cfg_pkg::chanCfg_t [1:0] chanCfg;
  hw_cfg_pkg::jaCfg_t jaCfg;
  logic rxClkFalling;
  logic inbandLoopEn;
  int n_fail;
  int cmp_count;
  logic [31:0] rd;
  logic err;

  hw_mode_config_pin_decoder uut (
    .clk(clk), .rstn(rstn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cfgPins(cfgPins), .chanCfg(chanCfg), .jaCfg(jaCfg),
    .rxClkFalling(rxClkFalling), .inbandLoopEn(inbandLoopEn)
  );

  cfg_strap_model straps (.clk(clk), .req(strapReq), .pins(cfgPins));

  // ==========================================================
  // Helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : tally_and_finish

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // No assumed latency: only the watchdog ends a hung wait
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic apply(input logic [15:0] v);
    @(posedge clk);
    strapReq <= v;
    repeat (5) @(posedge clk);
  endtask : apply

  function automatic logic [7:0] expCh(hw_cfg_pkg::chanPins_t p, logic hiz, logic tern);
    logic pd;
    pd = (p.txPatternSel == hw_cfg_pkg::TX_POWER_DOWN);
    return {p.txPatternSel, pd, ~(pd | hiz), p.loopbackSel,
            p.rxMonitorGainSel & tern, p.haulModeSel & tern};
  endfunction : expCh

  function automatic logic [10:0] expJa(logic [1:0] s);
    return {s != 2'h0, s == 2'h3, s[1], (s == 2'h0) ? 8'h00 : (s == 2'h1) ? 8'h40 : 8'h80};
  endfunction : expJa

  task automatic check_all(input logic tern);
    check(32'(chanCfg[0]), 32'(expCh(strapReq.chan[0], strapReq.txDriverHiz, tern)));
    check(32'(chanCfg[1]), 32'(expCh(strapReq.chan[1], strapReq.txDriverHiz, tern)));
    check(32'(jaCfg), 32'(expJa(strapReq.jitterAttenSel)));
    check(32'(rxClkFalling), 32'(strapReq.rxClockEdgeSel));
    check(32'(inbandLoopEn), 32'h0);
  endtask : check_all

  // ==========================================================
  // Scenarios
  task automatic reset_values;
    check(32'(chanCfg[0]), 32'h000000E0);
    check(32'(jaCfg), 32'h00000000);
  endtask : reset_values

  task automatic pin_sweep;
    logic [1:0] i;
    logic [1:0] j;
    for (int k = 0; k < 4; k++) begin
      i = 2'(k);
      j = 2'h3 - i;
      // Every pattern, loopback and attenuator code; hi-z on odd steps
      apply({i[1], i[0], i, j, j, ~i[0], ~i[1], i, i, i[0], i[1]});
      check_all(1'b1);
    end
  endtask : pin_sweep

  task automatic ternary_off;
    apb(1'b1, 12'h000, 32'h00000001);
    apply(16'h1B5B);
    check_all(1'b0);
    apb(1'b1, 12'h000, 32'h00000003);
    repeat (3) @(posedge clk);
    check_all(1'b1);
  endtask : ternary_off

  task automatic regs_and_inband;
    apb(1'b0, 12'h000, 32'h0);
    check(rd, 32'h00000003);
    apb(1'b0, 12'h004, 32'h0);
    check(rd, 32'h00004000);
    apb(1'b0, 12'h020, 32'h0);
    check({31'h0, err}, 32'h1);
    check(rd, 32'h0);
    apb(1'b1, 12'h004, 32'h0001FFFF);
    repeat (3) @(posedge clk);
    check_all(1'b1);
    apb(1'b0, 12'h00C, 32'h0);
    check(32'(rd[17]), 32'h0);
  endtask : regs_and_inband

  task automatic sw_mode;
    // Software image 0x1FFFF takes over once hardware mode is left
    apb(1'b1, 12'h000, 32'h00000000);
    repeat (3) @(posedge clk);
    check(32'(chanCfg[1]), 32'h000000EF);
    check(32'(jaCfg), 32'h00000780);
    check(32'(rxClkFalling), 32'h1);
    check(32'(inbandLoopEn), 32'h1);
    apb(1'b0, 12'h010, 32'h0);
    check(rd, 32'h00001B5B);
    apb(1'b0, 12'h008, 32'h0);
    check(rd, 32'h00EF00EF);
    apb(1'b1, 12'h000, 32'h00000003);
    repeat (3) @(posedge clk);
    check(32'(inbandLoopEn), 32'h0);
  endtask : sw_mode

  // ==========================================================
  // Clock, reset, sequence
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    tally_and_finish();
  end

  initial begin
    n_fail = 0;
    cmp_count = 0;
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    strapReq = '0;
    repeat (16) @(posedge clk);
    reset_values();
    rstn <= 1'b1;
    pin_sweep();
    ternary_off();
    regs_and_inband();
    sw_mode();
    tally_and_finish();
  end
endmodule : tb_hw_mode_config_pin_decoder
